// >>> design/fsc_menu_ctrl.sv
`timescale 1ns/1ps
`include "fsc_map.svh"
module fsc_menu_ctrl #(
  parameter int RPT_FIRST_CYC = `FSC_RPT_FIRST_MS * (`FSC_CLK_KHZ),
  parameter int RPT_NEXT_CYC = `FSC_RPT_NEXT_MS * (`FSC_CLK_KHZ)
) (
  input wire logic clk_sys, // 200 MHz system clock
  input wire logic rst, // power-on reset, synchronous
  input wire logic ce, // clock enable, freezes all state
  input wire logic [`FSC_NKEYS-1:0] key_n, // front-panel keys, low = pressed
  input wire logic load_dflt, // writes factory values to storage
  output logic setting_mode, // high while in setting mode
  output logic normal_run, // high while in normal operation
  output fsc_pkg::fsc_no_t disp_no, // setting number shown
  output fsc_pkg::fsc_val_t disp_val, // setting value shown
  output logic [3:0] flicker_lvl // committed flicker reduction level
);
  fsc_pkg::fsc_state_t state_q; // operating state
  logic [3:0] boot_cnt_q; // waits for synchronisers to fill
  logic armed_q; // keys released since entering mode
  fsc_pkg::fsc_no_t sel_q; // selected setting number
  fsc_pkg::fsc_no_t sel_d; // number after a step
  fsc_pkg::fsc_val_t edit_q; // volatile edited value
  fsc_pkg::fsc_val_t stor_q [`FSC_NO_FIRST:`FSC_NO_LAST]; // retained storage
  fsc_pkg::fsc_no_t disp_no_q; // indicator number register
  fsc_pkg::fsc_val_t disp_val_q; // indicator value register
  logic [3:0] flicker_q; // flicker level register
  logic [`FSC_NKEYS-1:0] sync1_q; // first synchroniser stage
  logic [`FSC_NKEYS-1:0] sync2_q; // second stage, pressed = high
  logic [`FSC_NKEYS-1:0] step; // per-key step pulses
  logic in_set; // setting mode and armed
  logic do_next; // step forward this cycle
  logic do_prev; // step back this cycle
  logic do_up; // raise value this cycle
  logic do_down; // lower value this cycle
  logic boot_done; // up key may be sampled now

  // refused at elaboration: repeat timers need at least one cycle
  if (RPT_FIRST_CYC < 1 || RPT_NEXT_CYC < 1) begin : g_bad_cnt
    $error("fsc_menu_ctrl: repeat counts must be at least one cycle");
  end

  // upper value limit per setting
  function automatic fsc_pkg::fsc_val_t lim_max(input fsc_pkg::fsc_no_t no);
    case (no)
      `FSC_NO_SOFT: lim_max = `FSC_MAX_SOFT;
      `FSC_NO_MKR4: lim_max = `FSC_MAX_MKR4;
      `FSC_NO_FLICKER: lim_max = `FSC_MAX_FLICKER;
      `FSC_NO_CNTUNIT: lim_max = `FSC_MAX_CNTUNIT;
      `FSC_NO_REVSPD: lim_max = `FSC_MAX_REVSPD;
      default: lim_max = `FSC_MAX_FLAG;
    endcase
  endfunction

  // lower value limit per setting
  function automatic fsc_pkg::fsc_val_t lim_min(input fsc_pkg::fsc_no_t no);
    if (no == `FSC_NO_REVSPD) begin
      lim_min = `FSC_MIN_REVSPD;
    end else begin
      lim_min = `FSC_MIN_ZERO;
    end
  endfunction

  // factory value per setting
  function automatic fsc_pkg::fsc_val_t dflt(input fsc_pkg::fsc_no_t no);
    case (no)
      `FSC_NO_FLICKER: dflt = `FSC_DFLT_FLICKER;
      `FSC_NO_REVSPD: dflt = `FSC_DFLT_REVSPD;
      default: dflt = `FSC_DFLT_OTHER;
    endcase
  endfunction

  // per key: two-flop synchroniser and repeat generator
  genvar gk;
  generate
    for (gk = 0; gk < `FSC_NKEYS; gk++) begin : g_key
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          sync1_q[gk] <= 1'b0;
          sync2_q[gk] <= 1'b0;
        end else if (ce) begin
          sync1_q[gk] <= ~key_n[gk];
          sync2_q[gk] <= sync1_q[gk];
        end
      end
      fsc_key_rpt #(
        .FIRST_CYC(RPT_FIRST_CYC),
        .NEXT_CYC(RPT_NEXT_CYC)
      ) u_rpt (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .key_lvl(sync2_q[gk]),
        .arm(armed_q),
        .step(step[gk])
      );
    end
  endgenerate

  // one action per cycle: next wins over previous over up over down
  assign in_set = ce && state_q == fsc_pkg::FSC_SETTING && armed_q;
  assign do_next = in_set && step[`FSC_K_NEXT];
  assign do_prev = in_set && !step[`FSC_K_NEXT] && step[`FSC_K_PREV];
  assign do_up = in_set && step[`FSC_K_NEXT:`FSC_K_PREV] == 2'b00 && step[`FSC_K_UP];
  assign do_down = in_set && step[`FSC_K_NEXT:`FSC_K_PREV] == 2'b00 && !step[`FSC_K_UP]
    && step[`FSC_K_DOWN];
  assign boot_done = boot_cnt_q == `FSC_BOOT_CYC;

  // next number, held at the ends of the list
  always_comb begin
    sel_d = sel_q;
    if (do_next && sel_q != `FSC_NO_LAST) begin
      sel_d = sel_q + `FSC_NO_FIRST;
    end else if (do_prev && sel_q != `FSC_NO_FIRST) begin
      sel_d = sel_q - `FSC_NO_FIRST;
    end
  end

  // power-on decision; only a new reset leaves setting mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= fsc_pkg::FSC_BOOT;
      boot_cnt_q <= 4'h0;
    end else if (ce) begin
      case (state_q)
        fsc_pkg::FSC_BOOT: begin
          if (!boot_done) begin
            boot_cnt_q <= boot_cnt_q + 4'h1;
          end else if (sync2_q[`FSC_K_UP]) begin
            state_q <= fsc_pkg::FSC_SETTING;
          end else begin
            state_q <= fsc_pkg::FSC_NORMAL;
          end
        end
        fsc_pkg::FSC_NORMAL: state_q <= fsc_pkg::FSC_NORMAL;
        fsc_pkg::FSC_SETTING: state_q <= fsc_pkg::FSC_SETTING;
        default: state_q <= fsc_pkg::FSC_BOOT;
      endcase
    end
  end

  // up key used to enter must be released before any key acts
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (ce && state_q == fsc_pkg::FSC_SETTING && sync2_q == 4'h0) begin
      armed_q <= 1'b1;
    end
  end

  // selected number and its volatile edit copy; reset drops the edit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_q <= `FSC_NO_START;
      edit_q <= `FSC_MIN_ZERO;
    end else if (ce) begin
      if (state_q == fsc_pkg::FSC_BOOT) begin
        edit_q <= stor_q[`FSC_NO_START];
      end else if (do_next || do_prev) begin
        sel_q <= sel_d;
        // at a list end the storage write lands this edge, so keep the edit shown
        edit_q <= (sel_d == sel_q) ? edit_q : stor_q[sel_d];
      end else if (do_up && edit_q < lim_max(sel_q)) begin
        edit_q <= edit_q + 12'h001;
      end else if (do_down && edit_q > lim_min(sel_q)) begin
        edit_q <= edit_q - 12'h001;
      end
    end
  end

  // retained storage: no reset, it models the non-volatile copy
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (load_dflt) begin
        for (int i = `FSC_NO_FIRST; i <= `FSC_NO_LAST; i++) begin
          stor_q[i] <= dflt(`FSC_NO_W'(i));
        end
      end else if (do_next || do_prev) begin
        stor_q[sel_q] <= edit_q;
      end
    end
  end

  // indicator and committed outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      disp_no_q <= `FSC_NO_START;
      disp_val_q <= `FSC_MIN_ZERO;
      flicker_q <= 4'h0;
    end else if (ce) begin
      disp_no_q <= sel_q;
      disp_val_q <= edit_q;
      // normal mode uses only committed values
      if (state_q == fsc_pkg::FSC_NORMAL) begin
        flicker_q <= stor_q[`FSC_NO_FLICKER][3:0];
      end
    end
  end

  assign setting_mode = state_q == fsc_pkg::FSC_SETTING;
  assign normal_run = state_q == fsc_pkg::FSC_NORMAL;
  assign disp_no = disp_no_q;
  assign disp_val = disp_val_q;
  assign flicker_lvl = flicker_q;

  // a step commits, then the new setting shows on the indicator
  sequence s_step;
    do_next || do_prev;
  endsequence
  sequence s_show_new;
    ##1 disp_val_q == stor_q[disp_no_q];
  endsequence

  chk_enter_setting: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state_q == fsc_pkg::FSC_BOOT && boot_done && sync2_q[`FSC_K_UP])
    |=> state_q == fsc_pkg::FSC_SETTING)
    else $error("up key at power-on did not enter setting mode");
  chk_enter_normal: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state_q == fsc_pkg::FSC_BOOT && boot_done && !sync2_q[`FSC_K_UP])
    |=> state_q == fsc_pkg::FSC_NORMAL)
    else $error("power-on without up key did not run normally");
  chk_next_inc: assert property (@(posedge clk_sys) disable iff (rst)
    (do_next && sel_q != `FSC_NO_LAST) |=> sel_q == $past(sel_q) + `FSC_NO_FIRST)
    else $error("next key did not advance the number");
  chk_prev_dec: assert property (@(posedge clk_sys) disable iff (rst)
    (do_prev && sel_q != `FSC_NO_FIRST) |=> sel_q == $past(sel_q) - `FSC_NO_FIRST)
    else $error("previous key did not return the number");
  chk_step_commit: assert property (@(posedge clk_sys) disable iff (rst)
    (s_step and !load_dflt) |=> stor_q[$past(sel_q)] == $past(edit_q))
    else $error("step did not commit the edited value");
  chk_show_new: assert property (@(posedge clk_sys) disable iff (rst)
    (s_step and !load_dflt) ##1 (ce && !load_dflt) |-> s_show_new)
    else $error("indicator did not show the new setting");
  chk_edit_no_commit: assert property (@(posedge clk_sys) disable iff (rst)
    (do_up || do_down) && !load_dflt |=> stor_q[sel_q] == $past(stor_q[sel_q]))
    else $error("value edit changed storage without a step");
  chk_flicker_range: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == fsc_pkg::FSC_SETTING && sel_q == `FSC_NO_FLICKER)
    |-> edit_q <= `FSC_MAX_FLICKER)
    else $error("flicker value above eight");
  chk_num_range: assert property (@(posedge clk_sys) disable iff (rst)
    sel_q >= `FSC_NO_FIRST && sel_q <= `FSC_NO_LAST)
    else $error("setting number outside list");
  chk_up_raise: assert property (@(posedge clk_sys) disable iff (rst)
    (do_up && edit_q < lim_max(sel_q)) |=> edit_q == $past(edit_q) + 12'h001)
    else $error("up key did not raise the value");
endmodule

// >>> design/fsc_map.svh
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
// widths of setting number and setting value
`define FSC_NO_W 4
`define FSC_VAL_W 12
// key indices into the key vector
`define FSC_K_PREV 0
`define FSC_K_NEXT 1
`define FSC_K_DOWN 2
`define FSC_K_UP 3
`define FSC_NKEYS 4
// setting number list and the one that opens the menu
`define FSC_NO_FIRST 4'h1
`define FSC_NO_LAST 4'hB
`define FSC_NO_START 4'h1
`define FSC_NO_FLICKER 4'h5
`define FSC_NO_SOFT 4'h1
`define FSC_NO_MKR4 4'h4
`define FSC_NO_CNTUNIT 4'h7
`define FSC_NO_REVSPD 4'h8
// value limits per setting
`define FSC_MAX_FLICKER 12'h008
`define FSC_MAX_SOFT 12'h009
`define FSC_MAX_MKR4 12'h013
`define FSC_MAX_CNTUNIT 12'h002
`define FSC_MAX_REVSPD 12'hBB8
`define FSC_MIN_REVSPD 12'h0B4
`define FSC_MAX_FLAG 12'h001
`define FSC_MIN_ZERO 12'h000
// factory values
`define FSC_DFLT_FLICKER 12'h000
`define FSC_DFLT_REVSPD 12'h0B4
`define FSC_DFLT_OTHER 12'h000
// cycles after reset release before the up key is sampled
`define FSC_BOOT_CYC 4'h3
// auto-repeat timing, milliseconds, and clock rate
`define FSC_RPT_FIRST_MS 500
`define FSC_RPT_NEXT_MS 100
`define FSC_CLK_KHZ 200000
`endif

// >>> design/fsc_pkg.sv
`include "fsc_map.svh"
package fsc_pkg;
  typedef enum logic [1:0] {FSC_BOOT, FSC_NORMAL, FSC_SETTING} fsc_state_t;
  typedef logic [`FSC_NO_W-1:0] fsc_no_t;
  typedef logic [`FSC_VAL_W-1:0] fsc_val_t;
endpackage

// >>> design/fsc_key_rpt.sv
`timescale 1ns/1ps
`include "fsc_map.svh"
module fsc_key_rpt #(
  parameter int FIRST_CYC = 100,
  parameter int NEXT_CYC = 20
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  input wire logic ce, // clock enable, freezes all state
  input wire logic key_lvl, // synchronised key level, high = pressed
  input wire logic arm, // keys accepted only while high
  output logic step // one-cycle step pulse
);
  logic prev_q; // key level one cycle ago
  logic [31:0] cnt_q; // cycles left until next repeat
  logic step_q; // registered step pulse

  // refused at elaboration: a zero count would wrap the timer to its largest value
  if (FIRST_CYC < 1 || NEXT_CYC < 1) begin : g_bad_cnt
    $error("fsc_key_rpt: repeat counts must be at least one cycle");
  end

  // press edge gives one step, holding repeats after FIRST_CYC, then every NEXT_CYC
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_q <= 1'b0;
      cnt_q <= 32'h00000000;
      step_q <= 1'b0;
    end else if (ce) begin
      prev_q <= key_lvl;
      if (!key_lvl || !arm) begin
        // released or not armed: no steps, timer idle
        cnt_q <= 32'h00000000;
        step_q <= 1'b0;
      end else if (!prev_q) begin
        step_q <= 1'b1;
        cnt_q <= 32'(FIRST_CYC - 1);
      end else if (cnt_q == 32'h00000000) begin
        step_q <= 1'b1;
        cnt_q <= 32'(NEXT_CYC - 1);
      end else begin
        step_q <= 1'b0;
        cnt_q <= cnt_q - 32'h00000001;
      end
    end
  end

  assign step = step_q;

  // a key still held when its timer runs out must step again
  chk_hold_repeat: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && key_lvl && arm && prev_q && cnt_q == 32'h00000000) |=> step_q)
    else $error("held key did not repeat");
endmodule

// >>> testbench/fsc_oper.sv
`timescale 1ns/1ps
// operator at the front panel, turns held keys into active-low pins
module fsc_oper (
  input wire logic clk_sys, // system clock
  input wire logic [3:0] hold, // keys the operator holds, high = held
  output logic [3:0] key_n // key pins, low = pressed
);
  // pins move just after the edge; a released key springs back high
  always_ff @(posedge clk_sys) begin
    key_n <= ~hold;
  end
endmodule

// >>> testbench/fsc_menu_ctrl_tb_top.sv
`timescale 1ns/1ps
module fsc_menu_ctrl_tb_top;
  logic clk_sys; // system clock
  logic rst; // power-on reset
  logic ce; // clock enable, high except for one short low stretch in the test
  logic load_dflt; // factory load strobe
  logic [3:0] hold; // keys held by operator
  logic [3:0] key_n; // key pins
  logic setting_mode; // dut mode flag
  logic normal_run; // dut run flag
  fsc_pkg::fsc_no_t disp_no; // shown number
  fsc_pkg::fsc_val_t disp_val; // shown value
  logic [3:0] flicker_lvl; // committed flicker level
  int err_count; // mismatches
  int tests_run; // comparisons
  logic [31:0] rng; // xorshift state
  int stor [1:11]; // model of retained storage
  int vmin [1:11]; // model lower limits
  int vmax [1:11]; // model upper limits
  int sel; // model selected number
  int edit; // model edit copy

  // short repeat times so held keys repeat within a few cycles
  fsc_menu_ctrl #(.RPT_FIRST_CYC(8), .RPT_NEXT_CYC(4)) DUT (.clk_sys(clk_sys), .rst(rst),
    .ce(ce), .key_n(key_n), .load_dflt(load_dflt), .setting_mode(setting_mode),
    .normal_run(normal_run), .disp_no(disp_no), .disp_val(disp_val),
    .flicker_lvl(flicker_lvl));
  fsc_oper oper (.clk_sys(clk_sys), .hold(hold), .key_n(key_n));

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk_n(input logic [3:0] got, input int exp);
    tests_run++;
    if (got !== 4'(exp)) begin
      err_count++;
      $display("Error at %0t: number %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_v(input fsc_pkg::fsc_val_t got, input int exp);
    tests_run++;
    if (got !== 12'(exp)) begin
      err_count++;
      $display("Error at %0t: value %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // model of one key action; a number step commits the edit first
  task automatic act(input int k);
    if (k < 2) begin
      stor[sel] = edit;
      sel = (k == 1) ? ((sel < 11) ? sel + 1 : 11) : ((sel > 1) ? sel - 1 : 1);
      edit = stor[sel];
    end else begin
      edit = edit + ((k == 3) ? 1 : -1);
      if (edit > vmax[sel]) edit = vmax[sel];
      if (edit < vmin[sel]) edit = vmin[sel];
    end
  endtask

  // power cycle with or without the up key held, edit copy is lost
  task automatic pwr(input logic up);
    int i;
    @(posedge clk_sys);
    hold <= up ? 4'h8 : 4'h0;
    rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    load_dflt <= 1'b0;
    sel = 1;
    edit = stor[1];
    for (i = 0; i < 20 && setting_mode !== 1'b1 && normal_run !== 1'b1; i++) begin
      @(posedge clk_sys);
    end
    if (i == 20) begin
      err_count++;
      $display("Error at %0t: no mode after power-up", $time);
      stop_test();
    end
    hold <= 4'h0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic show();
    chk_n(disp_no, sel);
    chk_v(disp_val, edit);
  endtask

  // short press, released before the first repeat
  task automatic press(input int k, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      hold <= 4'(1 << k);
      repeat (2) @(posedge clk_sys);
      hold <= 4'h0;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      act(k);
      show();
    end
  endtask

  // long hold, repeats run well past either end of the range
  task automatic hold_long(input int k);
    @(posedge clk_sys);
    hold <= 4'(1 << k);
    repeat (120) @(posedge clk_sys);
    hold <= 4'h0;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    repeat (30) act(k);
    show();
  endtask

  initial begin
    err_count = 0;
    tests_run = 0;
    rng = 32'h44E1D65E;
    ce = 1'b1;
    rst = 1'b1;
    load_dflt = 1'b1;
    hold = 4'h0;
    for (int i = 1; i <= 11; i++) begin
      vmin[i] = 0;
      vmax[i] = 1;
      stor[i] = (i == 8) ? 180 : 0;
    end
    vmax[1] = 9;
    vmax[4] = 19;
    vmax[5] = 8;
    vmax[7] = 2;
    vmax[8] = 3000;
    vmin[8] = 180;
    pwr(1'b0);
    chk_b(normal_run, 1'b1);
    chk_b(setting_mode, 1'b0);
    chk_n(flicker_lvl, 0);
    pwr(1'b1);
    chk_b(setting_mode, 1'b1);
    press(1, 4);
    rng = xs(rng);
    press(3, int'(rng[3:0]));
    hold_long(3);
    hold_long(2);
    press(3, 3);
    press(1, 1);
    press(0, 1);
    hold_long(1);
    // edit at the last number, a step there still commits and shows it
    press(3, 1);
    press(1, 1);
    hold_long(0);
    hold_long(2);
    press(1, 4);
    press(3, 1);
    // clock enable low: a key pressed meanwhile leaves no trace
    @(posedge clk_sys);
    ce <= 1'b0;
    hold <= 4'h2;
    repeat (4) @(posedge clk_sys);
    hold <= 4'h0;
    repeat (4) @(posedge clk_sys);
    ce <= 1'b1;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    show();
    pwr(1'b0);
    chk_b(normal_run, 1'b1);
    chk_n(flicker_lvl, stor[5]);
    pwr(1'b1);
    press(1, 4);
    stop_test();
  end
endmodule
